// ### rdc_chan_if.sv
// per-channel link between the control top and a fine offset estimator
`timescale 1ns/10ps
interface rdc_chan_if #(
	parameter int DW = 10
) ();
	logic signed [DW-1:0] sample;
	logic valid;
	logic en;
	logic clr;
	logic signed [DW-1:0] est;
	modport trk(input sample, input valid, input en, input clr, output est);
	modport ctl(output sample, output valid, output en, output clr, input est);
endinterface

// ### rdc_defs.svh
// named constants for the receive dc-offset and agc control block
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

// host register offsets
`define RDC_ADDR_CMD 6'h01
`define RDC_ADDR_PWR 6'h04
`define RDC_ADDR_CI 6'h18
`define RDC_ADDR_CQ 6'h19
`define RDC_ADDR_RSSI 6'h1a

// field positions and reset values
`define RDC_CMD_CAL_BIT 6
`define RDC_CMD_CAL_MASK 8'h40
`define RDC_PWR_MIX1_BIT 0
`define RDC_PWR_MIX2_BIT 1
`define RDC_PWR_LODIV_BIT 2
`define RDC_REG_RST 8'h00
`define RDC_COARSE_RST 8'sh00
`define RDC_COARSE_MAX 8'sh7f
`define RDC_COARSE_MIN 8'sh81

// calibration timing in bit periods
`define RDC_CAL_BITS 5'h19
`define RDC_CAL_COARSE_BITS 5'h08

// clock rate and rssi averaging times
`define RDC_CLK_KHZ 20000
`define RDC_RSSI_SLOW_MS 64
`define RDC_RSSI_FAST_US 500

// gain steps and agc thresholds
`define RDC_GAIN_MIN_DB (-5)
`define RDC_GAIN_STEP_DB 15
`define RDC_GAIN_LO 2'h0
`define RDC_GAIN_HI 2'h3
`define RDC_GAIN_RST 2'h3
`define RDC_AGC_LOW_DB 8'h18
`define RDC_AGC_HIGH_DB 8'h30
`define RDC_DB_PER_OCTAVE 8'h06
`define RDC_RSSI_MAX 8'hff

// estimator defaults
`define RDC_FINE_SHIFT 6
`define RDC_FINE_NOISE_LIM 64
`define RDC_COARSE_SHIFT 4

`endif

// ### rdc_fe_model.sv
// front-end and adc model: dc offset, noise, analogue coarse correction, bit timing
`timescale 1ns/10ps
module rdc_fe_model #(
	parameter int DW = 10
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// analogue controls and injected offsets
	input wire logic signed [7:0] coarse_i_i,
	input wire logic signed [7:0] coarse_q_i,
	input wire logic front_end_en_i,
	input wire logic signed [DW-1:0] dc_i_i,
	input wire logic signed [DW-1:0] dc_q_i,
	// samples and bit timing
	output logic signed [DW-1:0] adc_i_o,
	output logic signed [DW-1:0] adc_q_o,
	output logic adc_valid_o,
	output logic bit_tick_o
);
	logic [4:0] phase_reg;
	// front end on lets more noise through
	function automatic logic signed [DW-1:0] noise(input logic fe);
		return fe ? DW'($urandom_range(8)) - DW'(4) : DW'($urandom_range(4)) - DW'(2);
	endfunction
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			phase_reg <= 5'h00;
		end else begin
			phase_reg <= phase_reg + 5'h01;
		end
	end
	// eight samples per bit, tick kept off the sample slots
	always_ff @(posedge clock_i) begin
		adc_valid_o <= !sys_rst_i && phase_reg[1:0] == 2'h1;
		bit_tick_o <= !sys_rst_i && phase_reg == 5'h1e;
		adc_i_o <= dc_i_i - DW'(coarse_i_i) + noise(front_end_en_i);
		adc_q_o <= dc_q_i - DW'(coarse_q_i) + noise(front_end_en_i);
	end
endmodule

// ### rdc_fine_track.sv
// fine dc estimator: leaky average that skips large excursions
`timescale 1ns/10ps
`include "rdc_defs.svh"
module rdc_fine_track #(
	parameter int DW = 10,
	parameter int SH = `RDC_FINE_SHIFT,
	parameter int NOISE_LIM = `RDC_FINE_NOISE_LIM
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// channel link
	rdc_chan_if.trk chan
);
	localparam int AW = DW + SH;
	logic signed [AW-1:0] acc_reg;
	logic signed [DW:0] err_w;
	logic quiet_w;

	assign err_w = (DW+1)'(chan.sample) - (DW+1)'(chan.est);
	// large errors are signal, not noise
	assign quiet_w = (err_w < (DW+1)'(NOISE_LIM)) && (err_w > -((DW+1)'(NOISE_LIM))); // [R6]

	// state is kept while disabled so tracking resumes where it left off
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || chan.clr) begin
			acc_reg <= '0;
		end else if (chan.en && chan.valid && quiet_w) begin // [R6] [R7]
			acc_reg <= acc_reg + AW'(err_w);
		end
	end

	assign chan.est = DW'(acc_reg >>> SH);
endmodule

// ### rdc_pkg.sv
// types and shared functions for the receive dc-offset and agc control block
`include "rdc_defs.svh"
package rdc_pkg;
	typedef enum logic [4:0] {
		RDC_IDLE = 5'h01,
		RDC_RST = 5'h02,
		RDC_FE_OFF = 5'h04,
		RDC_TRACK = 5'h08,
		RDC_FE_ON = 5'h10
	} rdc_cal_state_t;

	typedef enum logic [1:0] {
		RDC_DC_HOLD = 2'h0,
		RDC_DC_FINE = 2'h1,
		RDC_DC_COARSE = 2'h2,
		RDC_DC_ZERO = 2'h3
	} rdc_dc_mode_t;

	// coarse log scale: db per octave times msb position
	function automatic logic [7:0] rdc_log_db(input logic [31:0] v);
		logic [7:0] idx;
		idx = 8'h00;
		for (int k = 0; k < 32; k++) begin
			if (v[k]) begin
				idx = 8'(k);
			end
		end
		return 8'(idx * `RDC_DB_PER_OCTAVE);
	endfunction

	function automatic int rdc_gain_db(input logic [1:0] g);
		return `RDC_GAIN_MIN_DB + `RDC_GAIN_STEP_DB * int'(g);
	endfunction
endpackage

// ### rdc_rssi_avg.sv
// signal level averaged over a selectable window, reported on a db scale
`timescale 1ns/10ps
`include "rdc_defs.svh"
module rdc_rssi_avg #(
	parameter int MW = 12,
	parameter int SLOW_CYC = `RDC_RSSI_SLOW_MS * `RDC_CLK_KHZ,
	parameter int FAST_CYC = `RDC_RSSI_FAST_US * `RDC_CLK_KHZ / 1000
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// magnitude samples
	input wire logic [MW-1:0] mag_i,
	input wire logic mag_valid_i,
	input wire logic fast_i,
	// averaged level
	output logic [7:0] level_db_o,
	output logic level_valid_o
);
	logic [31:0] cyc_reg;
	logic [31:0] sum_reg;
	logic [31:0] cnt_reg;
	logic [31:0] win_w;
	logic [7:0] ldb_sum;
	logic [7:0] ldb_cnt;
	logic win_end;

	assign win_w = fast_i ? 32'(FAST_CYC) : 32'(SLOW_CYC); // [R19]
	assign win_end = cyc_reg >= (win_w - 32'h1);
	// log of the mean is log of sum minus log of count
	assign ldb_sum = rdc_pkg::rdc_log_db(sum_reg);
	assign ldb_cnt = rdc_pkg::rdc_log_db(cnt_reg);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || win_end) begin
			cyc_reg <= '0;
		end else begin
			cyc_reg <= cyc_reg + 32'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || win_end) begin
			sum_reg <= '0;
			cnt_reg <= '0;
		end else if (mag_valid_i && (sum_reg <= ('1 - 32'(mag_i)))) begin
			sum_reg <= sum_reg + 32'(mag_i);
			cnt_reg <= cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			level_db_o <= '0;
			level_valid_o <= 1'b0;
		end else begin
			level_valid_o <= win_end;
			if (win_end) begin
				level_db_o <= (ldb_sum > ldb_cnt) ? (ldb_sum - ldb_cnt) : '0; // [R16]
			end
		end
	end
endmodule

// ### rdc_top.sv
// receive dc-offset calibration, agc and rssi control top
`timescale 1ns/10ps
`include "rdc_defs.svh"
// Contract
// R1: host command bit starts automatic calibration
// R2: reset, front end off, track 25 bits, restore
// R3: drive lna enable around front-end off steps
// R4: coarse measured first, then fine with it
// R5: hold mode freezes coarse and fine values
// R6: fine mode tracks fine offset, ignoring signal
// R7: coarse mode updates coarse, fine state frozen
// R8: reset-and-hold forces all offsets to zero
// R9: host reads and writes coarse offsets
// R10: no host path to fine offsets
// R11: demodulator subtracts averaged offset per sample
// R12: coarse registers drive analogue pre-adc correction
// R13: host should pick fine or hold afterwards
// R14: four gains, 15 dB apart, -5 to +40
// R15: agc hysteresis wider than one gain step
// R16: baseband level drives agc, host readable
// R17: device agc compensates reported signal strength
// R18: host agc means host compensates strength
// R19: averaging 64 ms default, 0.5 ms selectable
// R20: selectable inversion of received waveform
// R21: two bits power down receive mixer stages
// R22: selectable bypass of lo divide-by-two
// R23: count bit periods, ignore repeat requests
module rdc_top #(
	parameter int DW = 10,
	parameter int SLOW_CYC = `RDC_RSSI_SLOW_MS * `RDC_CLK_KHZ,
	parameter int FAST_CYC = `RDC_RSSI_FAST_US * `RDC_CLK_KHZ / 1000,
	parameter int COARSE_SHIFT = `RDC_COARSE_SHIFT
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// host register port
	input wire logic [5:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	output logic [7:0] host_rdata_o,
	// mode selects
	input wire logic [1:0] dc_mode_i,
	input wire logic agc_host_ctrl_i,
	input wire logic [1:0] agc_host_gain_i,
	input wire logic listen_before_transmit_i,
	input wire logic rx_invert_i,
	// adc samples and demodulator bit timing
	input wire logic signed [DW-1:0] adc_i_i,
	input wire logic signed [DW-1:0] adc_q_i,
	input wire logic adc_valid_i,
	input wire logic bit_tick_i,
	// corrected samples to demodulator
	output logic signed [DW:0] rx_i_o,
	output logic signed [DW:0] rx_q_o,
	output logic rx_valid_o,
	// analogue and front-end control
	output logic signed [7:0] coarse_i_o,
	output logic signed [7:0] coarse_q_o,
	output logic lna_en_o,
	output logic front_end_en_o,
	output logic rx_reset_o,
	output logic [1:0] gain_o,
	output logic rx_mixer_stage_one_power_o,
	output logic rx_mixer_stage_two_power_o,
	output logic lo_div_bypass_o,
	// status
	output logic [7:0] rssi_o,
	output logic rssi_valid_o,
	output logic cal_busy_o
);
	localparam int SW = DW + 6;

	rdc_pkg::rdc_cal_state_t cal_state_reg;
	rdc_pkg::rdc_cal_state_t cal_state_next;
	rdc_pkg::rdc_dc_mode_t mode_w;
	logic [4:0] bit_cnt_reg;
	logic [7:0] cmd_reg;
	logic [7:0] pwr_reg;
	logic lna_en_reg;
	logic [1:0] gain_reg;
	logic [7:0] rssi_reg;
	logic [7:0] lvl_db;
	logic lvl_valid;
	logic signed [7:0] coarse_w [2];
	logic signed [DW-1:0] est_w [2];
	logic signed [DW-1:0] adc_w [2];
	logic signed [DW:0] corr_w [2];
	logic [DW+1:0] mag_w;
	logic [8:0] rssi_sum;
	logic cal_idle;
	logic cal_req;
	logic coarse_phase;
	logic coarse_en;
	logic coarse_clr;
	logic fine_en;
	logic fine_clr;

	function automatic logic signed [7:0] sat8(input logic signed [SW-1:0] v);
		if (v > SW'(`RDC_COARSE_MAX)) begin
			return `RDC_COARSE_MAX;
		end else if (v < SW'(`RDC_COARSE_MIN)) begin
			return `RDC_COARSE_MIN;
		end
		return 8'(v);
	endfunction

	assign adc_w[0] = adc_i_i;
	assign adc_w[1] = adc_q_i;
	assign mode_w = rdc_pkg::rdc_dc_mode_t'(dc_mode_i);
	assign cal_idle = cal_state_reg == rdc_pkg::RDC_IDLE;
	assign cal_busy_o = !cal_idle;
	// a request while busy is dropped
	assign cal_req = host_wr_i && (host_addr_i == `RDC_ADDR_CMD) &&
		host_wdata_i[`RDC_CMD_CAL_BIT] && cal_idle; // [R1] [R23]

	// offset mode steering; hold enables neither estimator
	assign coarse_phase = (cal_state_reg == rdc_pkg::RDC_TRACK) &&
		(bit_cnt_reg < `RDC_CAL_COARSE_BITS);
	assign coarse_en = coarse_phase ||
		(cal_idle && mode_w == rdc_pkg::RDC_DC_COARSE); // [R4] [R7] [R5]
	assign fine_en = ((cal_state_reg == rdc_pkg::RDC_TRACK) && !coarse_phase) ||
		(cal_idle && mode_w == rdc_pkg::RDC_DC_FINE); // [R4] [R6] [R5]
	assign coarse_clr = (cal_state_reg == rdc_pkg::RDC_RST) ||
		(cal_idle && mode_w == rdc_pkg::RDC_DC_ZERO); // [R2] [R8]
	assign fine_clr = coarse_clr || coarse_phase; // [R4] [R8]

	// calibration sequencer
	always_comb begin
		cal_state_next = cal_state_reg;
		case (cal_state_reg)
			rdc_pkg::RDC_IDLE: begin
				if (cal_req) begin
					cal_state_next = rdc_pkg::RDC_RST; // [R1]
				end
			end
			rdc_pkg::RDC_RST: begin
				cal_state_next = rdc_pkg::RDC_FE_OFF; // [R2]
			end
			rdc_pkg::RDC_FE_OFF: begin
				if (bit_tick_i) begin
					cal_state_next = rdc_pkg::RDC_TRACK;
				end
			end
			rdc_pkg::RDC_TRACK: begin
				if (bit_tick_i && bit_cnt_reg == (`RDC_CAL_BITS - 5'h01)) begin
					cal_state_next = rdc_pkg::RDC_FE_ON; // [R2] [R23]
				end
			end
			rdc_pkg::RDC_FE_ON: begin
				cal_state_next = rdc_pkg::RDC_IDLE;
			end
			default: begin
				cal_state_next = rdc_pkg::RDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cal_state_reg <= rdc_pkg::RDC_IDLE;
		end else begin
			cal_state_reg <= cal_state_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i || cal_state_reg != rdc_pkg::RDC_TRACK) begin
			bit_cnt_reg <= '0;
		end else if (bit_tick_i) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01; // [R23]
		end
	end

	// front end and lna off from the reset step to the end of tracking
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			lna_en_reg <= 1'b1;
			rx_reset_o <= 1'b0;
		end else begin
			lna_en_reg <= !(cal_state_next == rdc_pkg::RDC_RST ||
				cal_state_next == rdc_pkg::RDC_FE_OFF ||
				cal_state_next == rdc_pkg::RDC_TRACK); // [R2] [R3]
			rx_reset_o <= cal_state_next == rdc_pkg::RDC_RST; // [R2]
		end
	end
	assign lna_en_o = lna_en_reg;
	assign front_end_en_o = lna_en_reg;

	// per-channel coarse and fine correction
	for (genvar g = 0; g < 2; g++) begin : gen_ch
		rdc_chan_if #(.DW(DW)) ch ();
		logic signed [SW-1:0] bit_sum_reg;
		logic signed [7:0] coarse_reg;
		logic host_hit;

		assign host_hit = host_wr_i &&
			(host_addr_i == ((g == 0) ? `RDC_ADDR_CI : `RDC_ADDR_CQ));
		assign ch.sample = adc_w[g];
		assign ch.valid = adc_valid_i;
		assign ch.en = fine_en;
		assign ch.clr = fine_clr;
		assign est_w[g] = ch.est;
		assign coarse_w[g] = coarse_reg;
		assign corr_w[g] = (DW+1)'(adc_w[g]) - (DW+1)'(ch.est); // [R11]

		rdc_fine_track #(.DW(DW)) u_trk (
			.clock_i(clock_i),
			.sys_rst_i(sys_rst_i),
			.chan(ch.trk)
		);

		always_ff @(posedge clock_i) begin
			if (sys_rst_i || bit_tick_i) begin
				bit_sum_reg <= '0;
			end else if (adc_valid_i) begin
				bit_sum_reg <= bit_sum_reg + SW'(adc_w[g]);
			end
		end

		// clear beats host write, host write beats tracking
		always_ff @(posedge clock_i) begin
			if (sys_rst_i || coarse_clr) begin
				coarse_reg <= `RDC_COARSE_RST; // [R8]
			end else if (host_hit) begin
				coarse_reg <= host_wdata_i; // [R9]
			end else if (coarse_en && bit_tick_i) begin
				coarse_reg <= sat8(SW'(coarse_reg) + (bit_sum_reg >>> COARSE_SHIFT)); // [R4] [R7]
			end
		end
	end

	assign coarse_i_o = coarse_w[0]; // [R12]
	assign coarse_q_o = coarse_w[1]; // [R12]

	// host registers
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cmd_reg <= `RDC_REG_RST;
			pwr_reg <= `RDC_REG_RST;
		end else if (host_wr_i) begin
			if (host_addr_i == `RDC_ADDR_CMD) begin
				cmd_reg <= host_wdata_i & ~`RDC_CMD_CAL_MASK;
			end
			if (host_addr_i == `RDC_ADDR_PWR) begin
				pwr_reg <= host_wdata_i;
			end
		end
	end
	assign rx_mixer_stage_one_power_o = pwr_reg[`RDC_PWR_MIX1_BIT]; // [R21]
	assign rx_mixer_stage_two_power_o = pwr_reg[`RDC_PWR_MIX2_BIT]; // [R21]
	assign lo_div_bypass_o = pwr_reg[`RDC_PWR_LODIV_BIT]; // [R22]

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			host_rdata_o <= `RDC_REG_RST;
		end else if (host_rd_i) begin
			case (host_addr_i)
				`RDC_ADDR_CMD: host_rdata_o <= cmd_reg | (cal_idle ? 8'h00 : `RDC_CMD_CAL_MASK);
				`RDC_ADDR_PWR: host_rdata_o <= pwr_reg;
				`RDC_ADDR_CI: host_rdata_o <= coarse_w[0]; // [R9]
				`RDC_ADDR_CQ: host_rdata_o <= coarse_w[1]; // [R9]
				`RDC_ADDR_RSSI: host_rdata_o <= rssi_reg; // [R16]
				default: host_rdata_o <= `RDC_REG_RST; // [R10]
			endcase
		end
	end

	// corrected samples, q negated when rx_invert_i is set to invert the spectrum
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rx_i_o <= '0;
			rx_q_o <= '0;
			rx_valid_o <= 1'b0;
		end else begin
			rx_valid_o <= adc_valid_i;
			if (adc_valid_i) begin
				rx_i_o <= corr_w[0]; // [R11]
				rx_q_o <= rx_invert_i ? -corr_w[1] : corr_w[1]; // [R20]
			end
		end
	end

	assign mag_w = (DW+2)'(rx_i_o < 0 ? -rx_i_o : rx_i_o) +
		(DW+2)'(rx_q_o < 0 ? -rx_q_o : rx_q_o);

	rdc_rssi_avg #(.MW(DW+2), .SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_rssi (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.mag_i(mag_w),
		.mag_valid_i(rx_valid_o),
		.fast_i(listen_before_transmit_i),
		.level_db_o(lvl_db),
		.level_valid_o(lvl_valid)
	);

	// agc: thresholds more than one step apart
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			gain_reg <= `RDC_GAIN_RST;
		end else if (agc_host_ctrl_i) begin
			gain_reg <= agc_host_gain_i;
		end else if (lvl_valid) begin
			if (lvl_db > `RDC_AGC_HIGH_DB && gain_reg != `RDC_GAIN_LO) begin
				gain_reg <= gain_reg - 2'h1; // [R15] [R16]
			end else if (lvl_db < `RDC_AGC_LOW_DB && gain_reg != `RDC_GAIN_HI) begin
				gain_reg <= gain_reg + 2'h1; // [R15]
			end
		end
	end
	assign gain_o = gain_reg; // [R14]

	// gain compensation relative to the highest gain
	assign rssi_sum = {1'b0, lvl_db} + 9'(rdc_pkg::rdc_gain_db(`RDC_GAIN_HI) -
		rdc_pkg::rdc_gain_db(gain_reg)); // [R14] [R17]

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rssi_reg <= '0;
			rssi_valid_o <= 1'b0;
		end else begin
			rssi_valid_o <= lvl_valid;
			if (lvl_valid) begin
				if (agc_host_ctrl_i) begin
					rssi_reg <= lvl_db; // [R18]
				end else begin
					rssi_reg <= rssi_sum[8] ? `RDC_RSSI_MAX : rssi_sum[7:0]; // [R17]
				end
			end
		end
	end
	assign rssi_o = rssi_reg;

	// checks
	logic [5:0] help_ticks;
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || cal_state_reg == rdc_pkg::RDC_IDLE) begin
			help_ticks <= '0;
		end else if (cal_state_reg == rdc_pkg::RDC_TRACK && bit_tick_i) begin
			help_ticks <= help_ticks + 6'h01;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	cal_start_a: assert property (cal_req |=> // [R1]
		(cal_state_reg == rdc_pkg::RDC_RST && rx_reset_o && !lna_en_o))
		else $error("calibration request did not start sequence");
	cal_length_a: assert property ((cal_state_reg == rdc_pkg::RDC_FE_ON) |-> // [R2]
		(help_ticks == 6'(`RDC_CAL_BITS)))
		else $error("tracking phase length wrong");
	lna_off_a: assert property ((cal_state_reg == rdc_pkg::RDC_TRACK) |-> // [R3]
		(!lna_en_o && !front_end_en_o))
		else $error("front end on during tracking");
	lna_back_a: assert property ((cal_state_reg == rdc_pkg::RDC_FE_ON) |=> // [R3]
		(lna_en_o && cal_state_reg == rdc_pkg::RDC_IDLE))
		else $error("front end not restored");
	coarse_first_a: assert property ((coarse_phase && $past(coarse_phase)) |-> // [R4]
		(est_w[0] == '0 && est_w[1] == '0))
		else $error("fine offset moved during coarse phase");
	hold_freeze_a: assert property ((cal_idle && mode_w == rdc_pkg::RDC_DC_HOLD && // [R5]
		!host_wr_i) |=> ($stable(coarse_w[0]) && $stable(est_w[0])))
		else $error("offsets changed in hold mode");
	fine_freeze_a: assert property ((cal_idle && mode_w == rdc_pkg::RDC_DC_COARSE) |=> // [R7]
		$stable(est_w[1]))
		else $error("fine offset changed in coarse mode");
	zero_hold_a: assert property ((cal_idle && mode_w == rdc_pkg::RDC_DC_ZERO) |=> // [R8]
		(coarse_w[0] == '0 && coarse_w[1] == '0 && est_w[0] == '0))
		else $error("offsets not zero in reset-and-hold");
	host_coarse_a: assert property ((host_wr_i && host_addr_i == `RDC_ADDR_CI && // [R9]
		cal_idle && mode_w != rdc_pkg::RDC_DC_ZERO) |=>
		(coarse_w[0] == $signed($past(host_wdata_i))))
		else $error("host coarse write lost");
	cal_ignore_a: assert property ((host_wr_i && host_addr_i == `RDC_ADDR_CMD && // [R23]
		host_wdata_i[`RDC_CMD_CAL_BIT] && !cal_idle) |=>
		(cal_state_reg != rdc_pkg::RDC_RST))
		else $error("calibration restarted while busy");
	agc_step_a: assert property ((!agc_host_ctrl_i && $past(!agc_host_ctrl_i)) |-> // [R15]
		(gain_o == $past(gain_o) || gain_o == $past(gain_o) + 2'h1 ||
		gain_o == $past(gain_o) - 2'h1))
		else $error("agc jumped more than one step");

	cal_done_c: cover property (cal_state_reg == rdc_pkg::RDC_FE_ON ##1 lna_en_o);
	gain_down_c: cover property (!agc_host_ctrl_i ##1 gain_o == $past(gain_o) - 2'h1);
	fast_rssi_c: cover property (listen_before_transmit_i && rssi_valid_o);
	coarse_track_c: cover property (cal_idle && coarse_en && bit_tick_i);
endmodule

// ### tb_rx_dc_offset_agc_control.sv
// self-checking bench for the receive dc-offset and agc control block
`timescale 1ns/10ps
`include "rdc_defs.svh"
module tb_rx_dc_offset_agc_control;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [5:0] host_addr_i = 6'h00;
	logic [7:0] host_wdata_i = 8'h00;
	logic host_wr_i = 1'b0;
	logic host_rd_i = 1'b0;
	logic [1:0] dc_mode_i = 2'h3;
	logic agc_host_ctrl_i = 1'b0;
	logic [1:0] agc_host_gain_i = 2'h0;
	logic listen_before_transmit_i = 1'b0;
	logic rx_invert_i = 1'b0;
	logic signed [9:0] dc_i = 10'h000;
	logic signed [9:0] dc_q = 10'h000;
	logic signed [9:0] adc_i, adc_q;
	logic adc_valid, bit_tick, rx_valid_o, lna_en_o, front_end_en_o, rx_reset_o;
	logic signed [10:0] rx_i_o, rx_q_o;
	logic signed [7:0] coarse_i_o, coarse_q_o;
	logic [7:0] host_rdata_o, rssi_o, rd_v;
	logic [1:0] gain_o;
	logic mix1_o, mix2_o, lodiv_o, rssi_valid_o, cal_busy_o;
	int error_cnt = 0;
	int samples_checked = 0;
	int cal_ticks = 0;
	int k, n, ei, eq;

	rdc_top #(.DW(10), .SLOW_CYC(64), .FAST_CYC(16)) dut_u (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_wr_i(host_wr_i),
		.host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o),
		.dc_mode_i(dc_mode_i), .agc_host_ctrl_i(agc_host_ctrl_i),
		.agc_host_gain_i(agc_host_gain_i), .listen_before_transmit_i(listen_before_transmit_i),
		.rx_invert_i(rx_invert_i), .adc_i_i(adc_i), .adc_q_i(adc_q),
		.adc_valid_i(adc_valid), .bit_tick_i(bit_tick),
		.rx_i_o(rx_i_o), .rx_q_o(rx_q_o), .rx_valid_o(rx_valid_o),
		.coarse_i_o(coarse_i_o), .coarse_q_o(coarse_q_o), .lna_en_o(lna_en_o),
		.front_end_en_o(front_end_en_o), .rx_reset_o(rx_reset_o), .gain_o(gain_o),
		.rx_mixer_stage_one_power_o(mix1_o), .rx_mixer_stage_two_power_o(mix2_o),
		.lo_div_bypass_o(lodiv_o), .rssi_o(rssi_o), .rssi_valid_o(rssi_valid_o),
		.cal_busy_o(cal_busy_o)
	);
	rdc_fe_model #(.DW(10)) fe_u (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .coarse_i_i(coarse_i_o),
		.coarse_q_i(coarse_q_o), .front_end_en_i(front_end_en_o), .dc_i_i(dc_i),
		.dc_q_i(dc_q), .adc_i_o(adc_i), .adc_q_o(adc_q), .adc_valid_o(adc_valid),
		.bit_tick_o(bit_tick)
	);

	initial begin
		forever #25 clock_i = ~clock_i;
	end
	// bit periods seen with the front end off during calibration
	always @(posedge clock_i) begin
		if (cal_busy_o === 1'b1 && lna_en_o === 1'b0 && bit_tick === 1'b1) begin
			cal_ticks++;
		end
	end

	function automatic logic [31:0] near(input int a, input int b, input int tol);
		return 32'((a - b <= tol) && (b - a <= tol));
	endfunction
	function automatic logic [31:0] rx_exp(input int v, input logic inv);
		return 32'(inv ? -v : v);
	endfunction
	// level plus the headroom below the top gain of 40 db
	function automatic logic [31:0] rssi_exp(input int lvl, input int g);
		return 32'(lvl + 40 - (15 * g - 5));
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cycles(input int c);
		repeat (c) @(posedge clock_i);
		#1;
	endtask
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		k = 0;
		while (s !== v && k < lim) begin
			@(posedge clock_i);
			#1;
			k++;
		end
		if (k >= lim) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock_i);
		host_addr_i <= a;
		host_wdata_i <= d;
		host_wr_i <= 1'b1;
		@(posedge clock_i);
		host_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge clock_i);
		host_addr_i <= a;
		host_rd_i <= 1'b1;
		@(posedge clock_i);
		host_rd_i <= 1'b0;
		#1;
		rd_v = host_rdata_o;
	endtask
	task automatic rx_exact(input int cnt);
		repeat (cnt) begin
			@(posedge clock_i);
			if (adc_valid === 1'b1) begin
				ei = adc_i;
				eq = adc_q;
				#1;
				check("rx_i", 32'(rx_i_o), rx_exp(ei, 1'b0));
				check("rx_q", 32'(rx_q_o), rx_exp(eq, rx_invert_i));
			end
		end
	endtask
	task automatic period();
		wait_lvl(rssi_valid_o, 1'b1, 300);
		n = 0;
		do begin
			@(posedge clock_i);
			#1;
			n++;
		end while (rssi_valid_o !== 1'b1 && n < 300);
		if (rssi_valid_o !== 1'b1) begin
			error_cnt++;
			give_verdict();
		end
	endtask

	initial begin
		k = $urandom(32'h42732efb);
		cycles(3);
		sys_rst_i <= 1'b0;
		cycles(1);
		check("gain rst", 32'(gain_o), 32'h3);
		check("lna rst", 32'(lna_en_o), 32'h1);
		rd(6'h3f);
		check("unmapped", 32'(rd_v), 32'h0);
		rd(6'h1b);
		check("no fine", 32'(rd_v), 32'h0);
		repeat (4) begin
			n = $urandom_range(7);
			wr(`RDC_ADDR_PWR, 8'(n));
			check("mix1", 32'(mix1_o), 32'(n & 1));
			check("mix2", 32'(mix2_o), 32'((n >> 1) & 1));
			check("lodiv", 32'(lodiv_o), 32'((n >> 2) & 1));
		end
		wr(`RDC_ADDR_CI, 8'h33);
		check("zero hold", 32'(coarse_i_o), 32'h0);
		dc_mode_i <= 2'h0;
		rx_invert_i <= 1'($urandom_range(1));
		dc_i <= 10'(int'($urandom_range(200)) - 100);
		dc_q <= 10'(int'($urandom_range(200)) - 100);
		n = int'($urandom_range(200)) - 100;
		wr(`RDC_ADDR_CI, 8'(n));
		wr(`RDC_ADDR_CQ, 8'(-n));
		check("coarse out", 32'(coarse_i_o), 32'(n));
		rd(`RDC_ADDR_CQ);
		check("coarse rd", 32'(rd_v), 32'(8'(-n)));
		rx_exact(200);
		check("hold", 32'(coarse_i_o), 32'(n));
		dc_mode_i <= 2'h1;
		wait_lvl(bit_tick, 1'b1, 100);
		cycles(2);
		cal_ticks = 0;
		wr(`RDC_ADDR_CMD, `RDC_CMD_CAL_MASK);
		check("busy", 32'(cal_busy_o), 32'h1);
		check("rx rst", 32'(rx_reset_o), 32'h1);
		check("lna off", 32'(lna_en_o), 32'h0);
		check("fe off", 32'(front_end_en_o), 32'h0);
		cycles(1);
		check("rst pulse", 32'(rx_reset_o), 32'h0);
		check("cal clr", 32'(coarse_i_o), 32'h0);
		wr(`RDC_ADDR_CMD, `RDC_CMD_CAL_MASK);
		rd(`RDC_ADDR_CMD);
		check("cmd busy", 32'(rd_v[`RDC_CMD_CAL_BIT]), 32'h1);
		wait_lvl(cal_busy_o, 1'b0, 3000);
		check("cal bits", 32'(cal_ticks), 32'd26);
		check("lna on", 32'(lna_en_o), 32'h1);
		check("cal i", near(coarse_i_o, dc_i, 3), 32'h1);
		check("cal q", near(coarse_q_o, dc_q, 3), 32'h1);
		dc_mode_i <= 2'h2;
		dc_i <= dc_i + 10'sd30;
		cycles(700);
		check("coarse trk", near(coarse_i_o, dc_i, 3), 32'h1);
		dc_mode_i <= 2'h1;
		dc_i <= 10'(coarse_i_o) + 10'sd20;
		cycles(3000);
		wait_lvl(rx_valid_o, 1'b1, 10);
		check("fine trk", near(rx_i_o, 0, 8), 32'h1);
		period();
		period();
		check("slow win", 32'(n), 32'd64);
		listen_before_transmit_i <= 1'b1;
		period();
		period();
		check("fast win", 32'(n), 32'd16);
		rd(`RDC_ADDR_RSSI);
		check("rssi rd", 32'(rd_v), 32'(rssi_o));
		agc_host_ctrl_i <= 1'b1;
		for (int g = 0; g < 4; g++) begin
			agc_host_gain_i <= 2'(g);
			cycles(2);
			check("host gain", 32'(gain_o), 32'(g));
		end
		agc_host_gain_i <= 2'h0;
		cycles(2);
		agc_host_ctrl_i <= 1'b0;
		repeat (6) period();
		check("agc quiet", 32'(gain_o), 32'h3);
		// strong carrier: mean |i|+|q| near 600, three samples a window, gives level 6*(10-1)
		dc_mode_i <= 2'h3;
		dc_i <= 10'sd300;
		dc_q <= 10'sd300;
		repeat (6) period();
		check("agc down", 32'(gain_o), 32'h0);
		check("rssi comp", 32'(rssi_o), rssi_exp(54, 0));
		agc_host_ctrl_i <= 1'b1;
		period();
		check("rssi host", 32'(rssi_o), 32'd54);
		give_verdict();
	end
endmodule
